// ==== bench/tb_top.sv ====
// Self-checking bench for the reset-cause flags, PLL divider and start-up delays.
// Assumes the design package and modules are compiled first; the bench drives every input itself except hready, which is tied to hreadyout.
`timescale 1ns/10ps
module tb_top;
	localparam int WL = 40;
	localparam int RS = 30;
	localparam int RL = 50;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic fuse = 1'b0;
	logic [3:0] src_sel = 4'h1;
	logic [1:0] start_sel = 2'h0;
	logic wake = 1'b0;
	logic [3:0] evt = 4'h0;
	logic fast_div;
	logic core_hold;
	logic irq;
	int bad_count = 0;
	int checked = 0;
	int seed = 32'he221;
	logic [3:0] cause = 4'h0;
	logic [31:0] rv;
	int hi;
	int tg;
	logic dprev;

	rcp_reset_cause #(.WAKE_LONG_CYC(WL), .RST_SHORT_CYC(RS), .RST_LONG_CYC(RL)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pll_sysclk_fuse(fuse),
		.clock_source_select(src_sel), .startup_time_select(start_sel), .wake_request(wake),
		.reset_event(evt), .fast_pll_clock_div(fast_div), .core_hold(core_hold), .irq(irq)
	);

	// Clock of 20 ns
	initial begin
		forever #10 hclk = ~hclk;
	end

	// Expected delay lengths in cycles
	function automatic int rst_len(input logic [1:0] s);
		return (s == 2'h1) ? RS : ((s == 2'h2) ? RL : 1);
	endfunction
	function automatic int wake_len(input logic [1:0] s);
		return (s == 2'h3) ? WL : rcp_pkg::RCP_WAKE_SHORT_CK;
	endfunction

	// Count a comparison and report a mismatch
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One AHB-Lite single transfer; ready and read data taken at the rising edge that completes each phase
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(what, exp, q);
		chk("bus response", 32'h0, {31'h0, hresp});
	endtask

	// Length of the next core hold, in cycles
	task automatic hold_len(output int len);
		len = 0;
		@(negedge hclk);
		for (int i = 0; i < 60 && core_hold !== 1'b1; i++) @(negedge hclk);
		while (core_hold === 1'b1 && len < 3000) begin
			len++;
			@(negedge hclk);
		end
	endtask

	// Reset event of one source with a given start-up code
	task automatic reset_case(input int idx, input logic [1:0] s);
		int len;
		@(posedge hclk);
		start_sel <= s;
		repeat (10) @(posedge hclk);
		fork
			begin
				evt[idx] <= 1'b1;
				repeat (8) @(posedge hclk);
				evt[idx] <= 1'b0;
			end
			hold_len(len);
		join
		chk("reset delay", rst_len(s), len);
		cause = (idx == 0) ? 4'h1 : (cause | (4'h1 << idx));
		rdchk("cause flags", 8'h34, {28'h0, cause});
	endtask

	// Wake delay started by pin or by control write
	task automatic wake_case(input logic [1:0] s, input logic by_pin);
		int len;
		@(posedge hclk);
		start_sel <= s;
		repeat (10) @(posedge hclk);
		fork
			if (by_pin) begin
				wake <= 1'b1;
				repeat (8) @(posedge hclk);
				wake <= 1'b0;
			end else begin
				wr(8'h44, 32'h1);
			end
			hold_len(len);
		join
		chk("wake delay", wake_len(s), len);
	endtask

	// Print the counts and the verdict, then stop
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Cut a hang short
	initial begin
		repeat (40000) @(posedge hclk);
		bad_count++;
		close_out();
	end

	// Main sequence
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rdchk("cause at reset", 8'h34, 32'h0);
		chk("irq at reset", 32'h0, {31'h0, irq});
		$display("test reset values finished");
		for (int s = 0; s < 4; s++) begin
			for (int i = 3; i >= 0; i--) reset_case(i, s[1:0]);
		end
		$display("test reset sources finished");
		wr(8'h34, 32'hff);
		rdchk("cause after ones", 8'h34, 32'h1);
		wr(8'h34, 32'hf0);
		cause = 4'h0;
		rdchk("cause after zero", 8'h34, 32'h0);
		wr(8'h50, 32'hffffffff);
		rdchk("unmapped", 8'h50, 32'h0);
		$display("test cause writes finished");
		// Random events with clear then read of the flags
		for (int k = 0; k < 12; k++) begin
			rv = $random(seed);
			if (rv[8]) reset_case(int'(rv[10:9]), rv[12:11]);
			wr(8'h34, rv);
			cause = cause & rv[3:0];
			rdchk("cause random", 8'h34, {28'h0, cause});
		end
		$display("test random flags finished");
		for (int s = 0; s < 4; s++) wake_case(s[1:0], s == 1);
		$display("test wake delays finished");
		// Interrupt: clear, raise masked, unmask, clear
		wr(8'h3c, 32'h0);
		wr(8'h38, 32'h3f);
		rdchk("irq status cleared", 8'h38, 32'h0);
		wake_case(2'h3, 1'b0);
		rdchk("irq status done", 8'h38, 32'h10);
		repeat (2) @(negedge hclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(8'h3c, 32'h10);
		rdchk("irq mask", 8'h3c, 32'h10);
		repeat (2) @(negedge hclk);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		wr(8'h38, 32'h10);
		repeat (2) @(negedge hclk);
		chk("irq after clear", 32'h0, {31'h0, irq});
		$display("test interrupt finished");
		// Divider: two high, two low in PLL mode, quiet otherwise
		for (int f = 0; f < 2; f++) begin
			@(posedge hclk);
			fuse <= f[0];
			repeat (12) @(posedge hclk);
			hi = 0;
			tg = 0;
			@(negedge hclk);
			dprev = fast_div;
			for (int c = 0; c < 16; c++) begin
				@(negedge hclk);
				hi += (fast_div === 1'b1);
				tg += (fast_div !== dprev);
				dprev = fast_div;
			end
			chk("divider high count", (f == 0) ? 32'd8 : 32'd0, hi);
			chk("divider toggles", (f == 0) ? 32'd8 : 32'd0, tg);
		end
		rdchk("sequencer status", 8'h40, {22'h0, start_sel, src_sel, 4'h8});
		// Wrong source select in PLL mode is flagged, then put right again
		@(posedge hclk);
		fuse <= 1'b0;
		src_sel <= 4'h2;
		repeat (12) @(posedge hclk);
		rdchk("config error status", 8'h40, {22'h0, start_sel, 4'h2, 4'h4});
		rdchk("config error flag", 8'h38, 32'h20);
		@(posedge hclk);
		src_sel <= 4'h1;
		$display("test divider finished");
		close_out();
	end
endmodule // tb_top

// ==== hdl/rcp_delay_timer.sv ====
// Down counter that times one start-up or reset delay.
// Assumes load is at least one; busy lasts exactly load cycles.
`timescale 1ns/10ps
module rcp_delay_timer #(
	parameter int CW = 22
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic start,
	input wire logic [CW-1:0] load,
	output logic busy,
	output logic done
);
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;
	logic next_busy;

	// Load on start, else count down while busy
	always_comb begin
		next_cnt = cnt;
		next_busy = busy;
		if (start) begin
			next_cnt = load - {{(CW-1){1'b0}}, 1'b1};
			next_busy = 1'b1;
		end else if (busy) begin
			next_cnt = cnt - {{(CW-1){1'b0}}, 1'b1};
			next_busy = (cnt != '0);
		end
	end

	// Last busy cycle
	assign done = busy && (cnt == '0) && !start;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= '0;
			busy <= 1'b0;
		end else begin
			cnt <= next_cnt;
			busy <= next_busy;
		end
	end
endmodule // rcp_delay_timer

// ==== hdl/rcp_pkg.sv ====
// Constants, types and register map of the reset-cause and PLL start-up block.
// Assumes an AHB-Lite master reaching the registers on a 50 MHz hclk.
// How it works
// - PLL fuse zero: system clock is PLL/4
// - Wake delay 1K cycles, 16K for code 11
// - Reset delay 4.1 ms code 01, 65 ms 10
// - Reserved cause bits read zero, ignore writes
// - Watchdog flag set by watchdog, cleared POR/zero
// - Brown-out flag set by brown-out, cleared POR/zero
// - External flag set by external, cleared POR/zero
// - Power-on flag set by POR, cleared zero
package rcp_pkg;

	// Register byte offsets
	localparam logic [7:0] RCP_OFF_CAUSE = 8'h34;
	localparam logic [7:0] RCP_OFF_IRQ_STAT = 8'h38;
	localparam logic [7:0] RCP_OFF_IRQ_MASK = 8'h3c;
	localparam logic [7:0] RCP_OFF_SEQ_STAT = 8'h40;
	localparam logic [7:0] RCP_OFF_CTRL = 8'h44;

	// Reset cause field positions
	localparam int RCP_BIT_POR = 0;
	localparam int RCP_BIT_EXT = 1;
	localparam int RCP_BIT_BOR = 2;
	localparam int RCP_BIT_WDT = 3;
	localparam int RCP_CAUSE_W = 4;

	// Interrupt status field positions
	localparam int RCP_IRQ_DONE = 4;
	localparam int RCP_IRQ_CFG = 5;
	localparam int RCP_IRQ_W = 6;

	// Control register: write one starts a wake delay
	localparam int RCP_CTRL_WAKE = 0;

	// Reset values
	localparam logic [3:0] RCP_CAUSE_RST = 4'h0;
	localparam logic [5:0] RCP_IRQ_RST = 6'h00;

	// Clock option values
	localparam logic [3:0] RCP_SRC_SEL_PLL = 4'h1;
	localparam int RCP_PLL_DIV = 4;
	localparam logic [1:0] RCP_START_LONG = 2'h3;
	localparam logic [1:0] RCP_START_4MS = 2'h1;
	localparam logic [1:0] RCP_START_65MS = 2'h2;

	// Timing: clock rate, cycle counts and delay times
	localparam int RCP_CLK_MHZ = 50;
	localparam int RCP_WAKE_SHORT_CK = 1024;
	localparam int RCP_WAKE_LONG_CK = 16384;
	localparam int RCP_RST_SHORT_US = 4100;
	localparam int RCP_RST_LONG_US = 65000;
	localparam int RCP_RST_SHORT_CYC = RCP_RST_SHORT_US * RCP_CLK_MHZ;
	localparam int RCP_RST_LONG_CYC = RCP_RST_LONG_US * RCP_CLK_MHZ;
	localparam int RCP_MIN_CYC = 1;
	localparam int RCP_CNT_W = 22;

	// Number of synchronised pin inputs
	localparam int RCP_PIN_W = 12;

	// Sequencer states
	typedef enum logic [1:0] {
		RCP_IDLE = 2'b00,
		RCP_RST_DLY = 2'b01,
		RCP_WAKE_DLY = 2'b10
	} rcp_state_t;

	// Reset events, one bit per source
	typedef struct packed {
		logic wdt;
		logic bor;
		logic ext;
		logic por;
	} rcp_evt_t;

	// Fuse straps and wake request after filtering
	typedef struct packed {
		logic wake;
		logic [1:0] start_sel;
		logic [3:0] src_sel;
		logic fuse;
	} rcp_cfg_t;

endpackage

// ==== hdl/rcp_reset_cause.sv ====
// Reset-cause flags, PLL system clock divider and start-up delay sequencer.
// Assumes one AHB-Lite master, fuse straps and reset events as asynchronous pins.
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/10ps
module rcp_reset_cause #(
	parameter int WAKE_LONG_CYC = rcp_pkg::RCP_WAKE_LONG_CK,
	parameter int RST_SHORT_CYC = rcp_pkg::RCP_RST_SHORT_CYC,
	parameter int RST_LONG_CYC = rcp_pkg::RCP_RST_LONG_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic pll_sysclk_fuse,
	input wire logic [3:0] clock_source_select,
	input wire logic [1:0] startup_time_select,
	input wire logic wake_request,
	input wire logic [3:0] reset_event,
	output logic fast_pll_clock_div,
	output logic core_hold,
	output logic irq
);
	localparam int CW = rcp_pkg::RCP_CNT_W;
	localparam int PW = rcp_pkg::RCP_PIN_W;

	// Three-flop synchroniser with agreement filter
	logic [PW-1:0] sync1;
	logic [PW-1:0] sync2;
	logic [PW-1:0] sync3;
	logic [PW-1:0] filt;
	logic [PW-1:0] next_filt;
	rcp_pkg::rcp_cfg_t cfg;
	rcp_pkg::rcp_evt_t evt;
	rcp_pkg::rcp_evt_t evt_q;
	rcp_pkg::rcp_evt_t evt_rise;
	logic wake_q;
	logic wake_rise;

	// A bit changes only when second and third stages agree
	always_comb begin
		next_filt = (sync2 & sync3) | (filt & (sync2 ^ sync3));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			filt <= '0;
			evt_q <= '0;
			wake_q <= 1'b0;
		end else begin
			sync1 <= {wake_request, startup_time_select, clock_source_select, pll_sysclk_fuse, reset_event};
			sync2 <= sync1;
			sync3 <= sync2;
			filt <= next_filt;
			evt_q <= evt;
			wake_q <= cfg.wake;
		end
	end

	// Split filtered pins into events and straps
	assign evt = filt[3:0];
	assign cfg = filt[PW-1:4];
	assign evt_rise = evt & ~evt_q;
	assign wake_rise = cfg.wake & ~wake_q;

	// PLL mode: fuse programmed to zero; a wrong source code in PLL mode is a config error
	logic pll_mode;
	logic cfg_err;
	assign pll_mode = !cfg.fuse;
	assign cfg_err = pll_mode && (cfg.src_sel != rcp_pkg::RCP_SRC_SEL_PLL);

	// Divide the PLL clock by four while PLL mode is selected
	logic [1:0] div_cnt;
	logic [1:0] next_div_cnt;
	logic next_clk_div;
	always_comb begin
		next_div_cnt = pll_mode ? div_cnt + 2'h1 : 2'h0;
		next_clk_div = pll_mode && next_div_cnt[1];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt <= 2'h0;
			fast_pll_clock_div <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			fast_pll_clock_div <= next_clk_div;
		end
	end

	// Bus address phase and register write strobes
	logic acc_ok;
	logic wr_pend;
	logic rd_pend;
	logic [7:0] acc_addr;
	logic next_wr_pend;
	logic next_rd_pend;
	logic [7:0] next_acc_addr;
	logic next_hreadyout;
	logic [31:0] next_hrdata;
	logic ctrl_wake;
	assign acc_ok = hsel && hready && htrans[1];

	// True when a pending write hits the given offset
	function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] off);
		wr_hit = pend && (a == off);
	endfunction

	// State of the sequencer and the flag registers
	rcp_pkg::rcp_state_t state;
	rcp_pkg::rcp_state_t next_state;
	logic [3:0] cause;
	logic [3:0] next_cause;
	logic [5:0] irq_stat;
	logic [5:0] next_irq_stat;
	logic [5:0] irq_mask;
	logic [5:0] next_irq_mask;
	logic cfg_err_q;
	logic tmr_start;
	logic [CW-1:0] tmr_load;
	logic tmr_busy;
	logic tmr_done;

	// Register read multiplexer
	function automatic logic [31:0] rd_mux(input logic [7:0] a);
		rd_mux = 32'h0000_0000;
		if (a == rcp_pkg::RCP_OFF_CAUSE) begin
			rd_mux = {28'h0000000, cause};
		end else if (a == rcp_pkg::RCP_OFF_IRQ_STAT) begin
			rd_mux = {26'h0000000, irq_stat};
		end else if (a == rcp_pkg::RCP_OFF_IRQ_MASK) begin
			rd_mux = {26'h0000000, irq_mask};
		end else if (a == rcp_pkg::RCP_OFF_SEQ_STAT) begin
			rd_mux = {22'h000000, cfg.start_sel, cfg.src_sel, cfg.fuse, cfg_err, state};
		end
	endfunction

	// Writes land in the data phase; reads take one wait state
	always_comb begin
		next_wr_pend = acc_ok && hwrite;
		next_rd_pend = acc_ok && !hwrite;
		next_acc_addr = acc_ok ? haddr[7:0] : acc_addr;
		next_hreadyout = !next_rd_pend;
		next_hrdata = rd_pend ? rd_mux(acc_addr) : hrdata;
	end

	assign ctrl_wake = wr_hit(wr_pend, acc_addr, rcp_pkg::RCP_OFF_CTRL) && hwdata[rcp_pkg::RCP_CTRL_WAKE];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			acc_addr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else begin
			wr_pend <= next_wr_pend;
			rd_pend <= next_rd_pend;
			acc_addr <= next_acc_addr;
			hreadyout <= next_hreadyout;
			hresp <= 1'b0;
			hrdata <= next_hrdata;
		end
	end

	// Reset cause flags: events set, power-on and written zeros clear
	logic [3:0] sw_clr;
	logic [3:0] por_clr;
	always_comb begin
		sw_clr = 4'h0;
		if (wr_hit(wr_pend, acc_addr, rcp_pkg::RCP_OFF_CAUSE)) begin
			sw_clr = ~hwdata[3:0];
		end
		por_clr = evt_rise.por ? 4'he : 4'h0;
		next_cause = (cause & ~sw_clr & ~por_clr) | evt_rise;
	end

	// Delay selection for reset and wake
	always_comb begin
		tmr_load = CW'(rcp_pkg::RCP_MIN_CYC);
		if (evt_rise != 4'h0) begin
			if (cfg.start_sel == rcp_pkg::RCP_START_4MS) begin
				tmr_load = CW'(RST_SHORT_CYC);
			end else if (cfg.start_sel == rcp_pkg::RCP_START_65MS) begin
				tmr_load = CW'(RST_LONG_CYC);
			end
		end else if (cfg.start_sel == rcp_pkg::RCP_START_LONG) begin
			tmr_load = CW'(WAKE_LONG_CYC);
		end else begin
			tmr_load = CW'(rcp_pkg::RCP_WAKE_SHORT_CK);
		end
	end

	// Sequencer: reset events restart, wake only from idle
	always_comb begin
		next_state = state;
		tmr_start = 1'b0;
		case (state)
			rcp_pkg::RCP_IDLE: begin
				if (wake_rise || ctrl_wake) begin
					next_state = rcp_pkg::RCP_WAKE_DLY;
					tmr_start = 1'b1;
				end
			end
			default: begin
				if (tmr_done) begin
					next_state = rcp_pkg::RCP_IDLE;
				end
			end
		endcase
		if (evt_rise != 4'h0) begin
			next_state = rcp_pkg::RCP_RST_DLY;
			tmr_start = 1'b1;
		end
	end

	rcp_delay_timer #(
		.CW(CW)
	) u_timer (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(tmr_start),
		.load(tmr_load),
		.busy(tmr_busy),
		.done(tmr_done)
	);

	// Interrupt flags: set wins over a write-one clear
	logic [5:0] irq_set;
	logic [5:0] irq_clr;
	always_comb begin
		irq_set = {cfg_err && !cfg_err_q, tmr_done, evt_rise};
		irq_clr = wr_hit(wr_pend, acc_addr, rcp_pkg::RCP_OFF_IRQ_STAT) ? hwdata[5:0] : 6'h00;
		next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
		next_irq_mask = wr_hit(wr_pend, acc_addr, rcp_pkg::RCP_OFF_IRQ_MASK) ? hwdata[5:0] : irq_mask;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= rcp_pkg::RCP_IDLE;
			cause <= rcp_pkg::RCP_CAUSE_RST;
			irq_stat <= rcp_pkg::RCP_IRQ_RST;
			irq_mask <= rcp_pkg::RCP_IRQ_RST;
			cfg_err_q <= 1'b0;
			core_hold <= 1'b0;
			irq <= 1'b0;
		end else begin
			state <= next_state;
			cause <= next_cause;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			cfg_err_q <= cfg_err;
			core_hold <= (next_state != rcp_pkg::RCP_IDLE);
			irq <= |(next_irq_stat & next_irq_mask);
		end
	end

	// Helper: length of the current hold and its kind
	logic [CW-1:0] hold_cnt;
	logic hold_wake;
	logic [1:0] hold_start_sel;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_cnt <= '0;
			hold_wake <= 1'b0;
			hold_start_sel <= 2'h0;
		end else begin
			hold_cnt <= tmr_start ? {{(CW-1){1'b0}}, 1'b1} : hold_cnt + {{(CW-1){1'b0}}, 1'b1};
			if (tmr_start) begin
				hold_wake <= (evt_rise == 4'h0);
				hold_start_sel <= cfg.start_sel;
			end
		end
	end

	a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_pend && (acc_addr == rcp_pkg::RCP_OFF_CAUSE) |=> hreadyout && (hrdata[31:4] == 28'h0000000))
		else $error("reserved cause bits not zero");
	a_wdt_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		evt_rise.wdt |=> cause[rcp_pkg::RCP_BIT_WDT])
		else $error("watchdog flag not set");
	a_bor_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		evt_rise.bor |=> cause[rcp_pkg::RCP_BIT_BOR])
		else $error("brown-out flag not set");
	a_ext_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
		evt_rise.ext |=> cause[rcp_pkg::RCP_BIT_EXT])
		else $error("external flag not set");
	a_por_clears_others: assert property (@(posedge hclk) disable iff (!hresetn)
		evt_rise == 4'h1 |=> cause == 4'h1)
		else $error("power-on did not set only its flag");
	a_one_keeps_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend && (acc_addr == rcp_pkg::RCP_OFF_CAUSE) && (hwdata[3:0] == 4'hf) && (evt_rise == 4'h0)
		|=> cause == $past(cause))
		else $error("writing one changed a cause flag");
	a_div_by_four: assert property (@(posedge hclk) disable iff (!hresetn)
		pll_mode && $past(pll_mode) && $rose(fast_pll_clock_div) |=> fast_pll_clock_div ##1 !fast_pll_clock_div)
		else $error("PLL clock not divided by four");
	a_wake_length: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(core_hold) && hold_wake && (hold_start_sel != rcp_pkg::RCP_START_LONG)
		|-> hold_cnt == CW'(rcp_pkg::RCP_WAKE_SHORT_CK + 1))
		else $error("wake delay length wrong");
	a_rst_length: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(core_hold) && !hold_wake && (hold_start_sel == rcp_pkg::RCP_START_4MS)
		|-> hold_cnt == CW'(RST_SHORT_CYC + 1))
		else $error("reset delay length wrong");
endmodule // rcp_reset_cause
